// ==== hdl/cab_pkg.sv ====
// Purpose: Shared constants and types for the add and bit-op datapath.
// Assumes: One clock, synchronous active-low reset, AXI4-Lite at 32 bits.
// Notes:   Register offsets are byte addresses of aligned words.
package cab_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [3:0] CAB_ACC_OFS = 4'h0; // Accumulator
  localparam logic [3:0] CAB_FLAG_OFS = 4'h4; // Status flags
  localparam logic [3:0] CAB_CFG_OFS = 4'h8; // Port and timer config

  // Flag field positions
  localparam int CAB_FL_C = 0; // Carry
  localparam int CAB_FL_NIB = 1; // nibble_overflow_flag
  localparam int CAB_FL_Z = 2; // Zero

  // Config field positions
  localparam int CAB_CFG_PORT_LSB = 0; // Port register address
  localparam int CAB_CFG_TMR_LSB = 8; // timer_zero_count address
  localparam int CAB_CFG_PRE_BIT = 16; // Prescaler assigned to timer

  // Reset values
  localparam logic [7:0] CAB_ACC_RST = 8'h00;
  localparam logic [2:0] CAB_FLAG_RST = 3'h0;
  localparam logic [6:0] CAB_PORT_RST = 7'h06;
  localparam logic [6:0] CAB_TMR_RST = 7'h01;
  localparam logic CAB_PRE_RST = 1'b0;

  // Bus answers
  localparam logic [1:0] CAB_RESP_OK = 2'h0;
  localparam logic [1:0] CAB_RESP_ERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Operations offered by the decoder
  typedef enum logic [3:0] {
    idle_op,
    add_immediate_op,
    add_register_op,
    and_immediate_op,
    and_register_op,
    single_bit_clear_op,
    single_bit_set_op,
    test_skip_if_zero_op,
    test_skip_if_one_op
  } cab_op_t;

  // One decoded instruction
  typedef struct packed {
    logic valid; // Instruction present this cycle
    cab_op_t op; // Operation
    logic [6:0] addr; // File register address
    logic [2:0] bitsel; // Bit position
    logic dest; // 0 accumulator, 1 register
    logic [7:0] literal; // Immediate value
  } cab_instr_t;

  // File register write-back
  typedef struct packed {
    logic en; // Write strobe
    logic [6:0] addr; // Target address
    logic [7:0] data; // Value to store
  } cab_wb_t;

endpackage : cab_pkg

// ==== hdl/cab_core.sv ====
// Purpose: Execute add, AND and single-bit instructions of the CPU.
// Assumes: Decoder holds one instruction per cycle; file data is comb.
// Notes:   Results land one edge after the instruction is offered.
`timescale 1ns/1ps
module cab_core
  import cab_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Instruction from decoder
  input wire cab_instr_t instr,
  // File register read side
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pin_rdata,
  // Execution results
  output cab_wb_t wb_q,
  output logic skip_q,
  output logic presc_clr_q,
  output logic [7:0] acc_q,
  output logic [2:0] flag_q,
  // AXI4-Lite write address
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // AXI4-Lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic squash_q; // Next instruction becomes idle
  logic [6:0] port_addr_q; // Address read from pins
  logic [6:0] tmr_addr_q; // Timer counter address
  logic pre_asgn_q; // Prescaler belongs to timer
  logic [3:0] aw_addr_q; // Held write address
  logic [31:0] w_data_q; // Held write data
  logic [3:0] w_strb_q; // Held byte strobes
  logic [31:0] mask_c; // Byte strobes as bit mask
  logic sw_wr_c; // Register write this edge
  logic [31:0] acc_wv_c; // Masked accumulator write
  logic [31:0] flag_wv_c; // Masked flag write
  logic [31:0] cfg_wv_c; // Masked config write
  logic go_c; // Instruction really executes
  logic [7:0] opnd_c; // File operand
  logic [8:0] sum_c; // Nine-bit sum
  logic [4:0] nib_c; // Low nibble sum
  logic [7:0] res_c; // Datapath result
  logic bit_c; // Tested bit
  logic to_acc_c; // Result goes to accumulator
  logic to_reg_c; // Result goes to register
  logic arith_c; // Sets carry and nibble flags
  logic sets_z_c; // Updates zero flag
  logic skip_c; // Skip condition met

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch and datapath
  assign go_c = instr.valid && !squash_q;
  // Port registers read their pin levels
  assign opnd_c = (instr.addr == port_addr_q) ? pin_rdata : file_rdata;
  assign sum_c = {1'b0, acc_q} + {1'b0,
    (instr.op == add_immediate_op) ? instr.literal : opnd_c};
  assign nib_c = {1'b0, acc_q[3:0]} + {1'b0,
    (instr.op == add_immediate_op) ? instr.literal[3:0] : opnd_c[3:0]};
  assign bit_c = opnd_c[instr.bitsel];

  // Result and destination per operation
  always_comb begin
    res_c = opnd_c;
    to_acc_c = 1'b0;
    to_reg_c = 1'b0;
    arith_c = 1'b0;
    sets_z_c = 1'b0;
    skip_c = 1'b0;
    unique case (instr.op)
      idle_op: begin
        res_c = opnd_c;
      end
      add_immediate_op: begin
        res_c = sum_c[7:0];
        to_acc_c = 1'b1;
        arith_c = 1'b1;
        sets_z_c = 1'b1;
      end
      add_register_op: begin
        res_c = sum_c[7:0];
        to_acc_c = !instr.dest;
        to_reg_c = instr.dest;
        arith_c = 1'b1;
        sets_z_c = 1'b1;
      end
      and_immediate_op: begin
        res_c = acc_q & instr.literal;
        to_acc_c = 1'b1;
        sets_z_c = 1'b1;
      end
      and_register_op: begin
        res_c = acc_q & opnd_c;
        to_acc_c = !instr.dest;
        to_reg_c = instr.dest;
        sets_z_c = 1'b1;
      end
      single_bit_clear_op: begin
        res_c = opnd_c & ~(8'h01 << instr.bitsel);
        to_reg_c = 1'b1;
      end
      single_bit_set_op: begin
        res_c = opnd_c | (8'h01 << instr.bitsel);
        to_reg_c = 1'b1;
      end
      test_skip_if_zero_op: begin
        skip_c = !bit_c;
      end
      test_skip_if_one_op: begin
        skip_c = bit_c;
      end
      default: res_c = opnd_c; // Unused op codes act as idle
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip handling: discard the following instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      squash_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      squash_q <= go_c && skip_c;
      skip_q <= go_c && skip_c;
    end
  end

  // File register write-back and prescaler clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_q <= '0;
      presc_clr_q <= 1'b0;
    end else begin
      wb_q.en <= go_c && to_reg_c;
      wb_q.addr <= instr.addr;
      wb_q.data <= res_c;
      // Timer counter write resets its prescaler
      presc_clr_q <= go_c && to_reg_c && pre_asgn_q &&
        (instr.addr == tmr_addr_q);
    end
  end

  // Accumulator: executing instruction beats software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= CAB_ACC_RST;
    end else if (go_c && to_acc_c) begin
      acc_q <= res_c;
    end else if (sw_wr_c && aw_addr_q == CAB_ACC_OFS) begin
      acc_q <= acc_wv_c[7:0];
    end
  end

  // Status flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= CAB_FLAG_RST;
    end else if (go_c && sets_z_c) begin
      flag_q[CAB_FL_Z] <= (res_c == 8'h00);
      if (arith_c) begin
        flag_q[CAB_FL_C] <= sum_c[8];
        flag_q[CAB_FL_NIB] <= nib_c[4];
      end
    end else if (sw_wr_c && aw_addr_q == CAB_FLAG_OFS) begin
      flag_q <= flag_wv_c[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: byte mask from strobes
  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign mask_c[8*i +: 8] = {8{w_strb_q[i]}};
  end
  assign sw_wr_c = !s_awready && !s_wready && !s_bvalid;
  assign acc_wv_c = ({24'h0000_00, acc_q} & ~mask_c) | (w_data_q & mask_c);
  assign flag_wv_c = ({29'h0000_000, flag_q} & ~mask_c) |
    (w_data_q & mask_c);
  assign cfg_wv_c = ({15'h0000, pre_asgn_q, 1'b0, tmr_addr_q, 1'b0,
    port_addr_q} & ~mask_c) | (w_data_q & mask_c);

  // Write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        aw_addr_q <= s_awaddr;
      end else if (s_bvalid && s_bready) begin
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end else if (s_bvalid && s_bready) begin
        s_wready <= 1'b1;
      end
    end
  end

  // Write response once both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= CAB_RESP_OK;
    end else if (sw_wr_c) begin
      s_bvalid <= 1'b1;
      s_bresp <= (aw_addr_q == CAB_ACC_OFS || aw_addr_q == CAB_FLAG_OFS ||
        aw_addr_q == CAB_CFG_OFS) ? CAB_RESP_OK : CAB_RESP_ERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_addr_q <= CAB_PORT_RST;
      tmr_addr_q <= CAB_TMR_RST;
      pre_asgn_q <= CAB_PRE_RST;
    end else if (sw_wr_c && aw_addr_q == CAB_CFG_OFS) begin
      port_addr_q <= cfg_wv_c[CAB_CFG_PORT_LSB +: 7];
      tmr_addr_q <= cfg_wv_c[CAB_CFG_TMR_LSB +: 7];
      pre_asgn_q <= cfg_wv_c[CAB_CFG_PRE_BIT];
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= CAB_RESP_OK;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= CAB_RESP_OK;
      unique case (s_araddr)
        CAB_ACC_OFS: s_rdata <= {24'h0000_00, acc_q};
        CAB_FLAG_OFS: s_rdata <= {29'h0000_000, flag_q};
        CAB_CFG_OFS: s_rdata <= {15'h0000, pre_asgn_q, 1'b0, tmr_addr_q,
          1'b0, port_addr_q};
        default: begin
          s_rdata <= '0;
          s_rresp <= CAB_RESP_ERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  add_imm_acc_a:
    assert property (go_c && instr.op == add_immediate_op |=>
      acc_q == 8'($past(acc_q) + $past(instr.literal)))
    else $error("add immediate result wrong");
  add_reg_dest_a:
    assert property (go_c && instr.op == add_register_op && instr.dest |=>
      wb_q.en && wb_q.data == 8'($past(acc_q) + $past(opnd_c)))
    else $error("add register write-back wrong");
  and_imm_flags_a:
    assert property (go_c && instr.op == and_immediate_op |=>
      $stable(flag_q[1:0]) && acc_q == ($past(acc_q) & $past(instr.literal)))
    else $error("and immediate touched carry");
  and_reg_acc_a:
    assert property (go_c && instr.op == and_register_op && !instr.dest |=>
      !wb_q.en && acc_q == ($past(acc_q) & $past(opnd_c)))
    else $error("and register result wrong");
  bit_clear_a:
    assert property (go_c && instr.op == single_bit_clear_op |=>
      wb_q.en && !wb_q.data[$past(instr.bitsel)] && $stable(flag_q))
    else $error("bit clear wrong");
  bit_set_a:
    assert property (go_c && instr.op == single_bit_set_op |=>
      wb_q.en && wb_q.data[$past(instr.bitsel)] && $stable(flag_q))
    else $error("bit set wrong");
  skip_zero_a:
    assert property (go_c && instr.op == test_skip_if_zero_op && !bit_c |=>
      skip_q ##1 (!wb_q.en && !skip_q))
    else $error("skip on clear bit missed");
  skip_one_a:
    assert property (go_c && instr.op == test_skip_if_one_op |=>
      skip_q == $past(bit_c) && $stable(flag_q))
    else $error("skip on set bit wrong");
  no_stall_a:
    assert property (go_c && !skip_c |=> !squash_q)
    else $error("extra cycle without skip");
  pin_operand_a:
    assert property (go_c && instr.op == and_register_op && instr.dest &&
      instr.addr == port_addr_q |=>
      wb_q.data == ($past(acc_q) & $past(pin_rdata)))
    else $error("port operand not from pins");
  presc_clear_a:
    assert property (wb_q.en && wb_q.addr == $past(tmr_addr_q) &&
      $past(pre_asgn_q) |-> presc_clr_q)
    else $error("prescaler not cleared");
  add_carry_a:
    assert property (go_c && instr.op == add_immediate_op |=>
      flag_q[CAB_FL_C] == $past(sum_c[8]) && flag_q[CAB_FL_Z] == (acc_q == 0))
    else $error("add flags wrong");

endmodule : cab_core

// ==== tb/cab_file_model.sv ====
// Purpose: File register memory that faces the datapath.
// Assumes: Latch read is combinational on the offered address.
// Notes:   Pins read as the latch inverted, so the operand source shows.
`timescale 1ns/1ps
module cab_file_model
  import cab_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Datapath side
  input wire cab_instr_t instr,
  input wire cab_wb_t wb_q,
  output logic [7:0] file_rdata,
  output logic [7:0] pin_rdata
);
  logic [7:0] mem [128]; // Latch contents
  //////////////////////////////////////////////////////////////////////////
  // Each word starts as its own address
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = i[7:0];
    end
  end
  // Latch and pin reads
  assign file_rdata = mem[instr.addr];
  assign pin_rdata = ~mem[instr.addr];
  // Write-back lands at the edge it is seen
  always @(posedge aclk) begin
    if (wb_q.en === 1'b1) begin
      mem[wb_q.addr] <= wb_q.data;
    end
  end
endmodule : cab_file_model

// ==== tb/cab_core_test.sv ====
// Purpose: Self-checking bench for the add and bit-op datapath.
// Assumes: Results show one edge after an instruction is offered.
// Notes:   Registers reached over AXI4-Lite tasks.
`timescale 1ns/1ps
module cab_core_test
  import cab_pkg::*;
();
  logic aclk, aresetn, skip_q, presc_clr_q;
  cab_instr_t instr; // Decoder stimulus
  cab_wb_t wb_q;
  logic [7:0] file_rdata, pin_rdata, acc_q;
  logic [2:0] flag_q;
  logic [3:0] s_awaddr, s_wstrb, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int error_cnt = 0;
  int comparisons = 0;
  //////////////////////////////////////////////////////////////////////////
  cab_core u_cab_core (.aclk(aclk), .aresetn(aresetn), .instr(instr),
    .file_rdata(file_rdata), .pin_rdata(pin_rdata), .wb_q(wb_q),
    .skip_q(skip_q), .presc_clr_q(presc_clr_q), .acc_q(acc_q),
    .flag_q(flag_q), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  cab_file_model u_cab_file_model (.aclk(aclk), .instr(instr),
    .wb_q(wb_q), .file_rdata(file_rdata), .pin_rdata(pin_rdata));
  //////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // Compare and report
  task automatic check(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // Bus write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_awready) aw = 1'b0;
      if (s_wready) w = 1'b0;
      s_awvalid <= aw;
      s_wvalid <= w;
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  // Bus read
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  // Offer one instruction for one cycle
  task automatic issue(input cab_op_t op, input logic [6:0] a,
                       input logic [2:0] b, input logic d,
                       input logic [7:0] k);
    @(posedge aclk);
    instr <= '{1'b1, op, a, b, d, k};
    #1;
  endtask : issue
  task automatic idle();
    @(posedge aclk);
    instr.valid <= 1'b0;
    #1;
  endtask : idle
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(CAB_CFG_OFS, d, r);
    check("cfg reset", d, 32'h0000_0106);
    rd(CAB_FLAG_OFS, d, r);
    check("flag reset", d, 32'h0000_0000);
    rd(4'hC, d, r);
    check("rd unmapped", r, CAB_RESP_ERR);
    wr(4'hC, 32'h0000_00FF, r);
    check("wr unmapped", r, CAB_RESP_ERR);
    wr(CAB_ACC_OFS, 32'h0000_00F8, r);
    rd(CAB_ACC_OFS, d, r);
    check("acc rd", d, 32'h0000_00F8);
  endtask : t_regs
  task automatic t_add();
    logic [1:0] r;
    issue(add_immediate_op, 7'h00, 3'd0, 1'b0, 8'h08);
    idle();
    check("addi acc", acc_q, 32'h0000_0000);
    check("addi flags", flag_q, 3'b111);
    wr(CAB_ACC_OFS, 32'h0000_000F, r);
    issue(add_register_op, 7'h21, 3'd0, 1'b1, 8'h00);
    idle();
    idle();
    check("addr mem", u_cab_file_model.mem[33], 8'h30);
    check("addr acc", acc_q, 8'h0F);
    check("addr flags", flag_q, 3'b010);
    issue(add_register_op, 7'h7F, 3'd0, 1'b0, 8'h00);
    issue(add_register_op, 7'h7F, 3'd0, 1'b0, 8'h00);
    check("addr acc 1", acc_q, 8'h8E);
    idle();
    check("addr acc 2", acc_q, 8'h0D);
    check("addr carry", flag_q, 3'b011);
  endtask : t_add
  task automatic t_and();
    logic [1:0] r;
    issue(and_immediate_op, 7'h00, 3'd0, 1'b0, 8'h00);
    idle();
    check("andi acc", acc_q, 8'h00);
    check("andi flags", flag_q, 3'b111);
    wr(CAB_ACC_OFS, 32'h0000_00FF, r);
    issue(and_register_op, 7'h06, 3'd0, 1'b1, 8'h00);
    idle();
    idle();
    check("andr pin", u_cab_file_model.mem[6], 8'hF9);
    check("andr acc", acc_q, 8'hFF);
    check("andr flags", flag_q, 3'b011);
  endtask : t_and
  task automatic t_bits();
    issue(single_bit_clear_op, 7'h40, 3'd6, 1'b0, 8'h00);
    issue(single_bit_set_op, 7'h41, 3'd7, 1'b0, 8'h00);
    idle();
    idle();
    check("clear", u_cab_file_model.mem[64], 8'h00);
    check("set", u_cab_file_model.mem[65], 8'hC1);
    check("bit flags", flag_q, 3'b011);
  endtask : t_bits
  // Test op, then an add that a taken skip must drop
  task automatic skip_case(input cab_op_t op, input logic [6:0] a,
                           input logic [2:0] b, input logic sk);
    logic [1:0] r;
    wr(CAB_ACC_OFS, 32'h0000_0010, r);
    issue(op, a, b, 1'b0, 8'h00);
    issue(add_immediate_op, 7'h00, 3'd0, 1'b0, 8'h01);
    check("skip", skip_q, sk);
    idle();
    check("skip acc", acc_q, sk ? 8'h10 : 8'h11);
    check("skip end", skip_q, 1'b0);
  endtask : skip_case
  task automatic t_presc();
    logic [1:0] r;
    wr(CAB_CFG_OFS, 32'h0001_0106, r);
    issue(add_register_op, 7'h01, 3'd0, 1'b1, 8'h00);
    idle();
    check("presc clr", presc_clr_q, 1'b1);
    issue(add_register_op, 7'h01, 3'd0, 1'b0, 8'h00);
    idle();
    check("presc keep", presc_clr_q, 1'b0);
  endtask : t_presc
  //////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
  // Main sequence
  initial begin
    aresetn = 1'b0;
    instr = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_add();
    t_and();
    t_bits();
    skip_case(test_skip_if_zero_op, 7'h40, 3'd0, 1'b1);
    skip_case(test_skip_if_zero_op, 7'h41, 3'd0, 1'b0);
    skip_case(test_skip_if_one_op, 7'h41, 3'd7, 1'b1);
    skip_case(test_skip_if_one_op, 7'h40, 3'd3, 1'b0);
    t_presc();
    conclude();
  end
endmodule : cab_core_test
